//--- design/amsc_top.sv
// auxiliary motor staging controller with apb register slave
// Notes on behaviour
// - relay one, relay two, digital output one drive motors when function is 24.
// - extension card present adds relay outputs; fourth motor needs it.
// - motor total 0..4, first index 1..4, start order cycles from it.
// - motors stop in reverse start order, last started first.
// - running motor count 0..4 is readable.
// - start needs freq above start threshold, on delay done, error above limit.
// - stop needs freq below stop threshold, off delay done, error below limit.
// - pid error compared with pressure threshold 0..100 percent, default 2.
// - pid and normal ramp held while a motor is switched.
// - on start, main motor ramps down to stop threshold over decel time.
// - on stop, main motor ramps up to start threshold over accel time.
// - staging works only when application mode is 3.
// - rotation mode none, aux only or all motors; default aux only.
// - rotation none always starts at the configured first motor.
// - runtime over limit plus main stop advances first index with wrap.
`timescale 1ns/10ps
module amsc_top import amsc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // main motor loop status
  input wire logic main_running,
  input wire logic [15:0] main_freq,
  input wire logic signed [7:0] pid_error,
  input wire logic ext_card_present,
  // motor contactor outputs
  output logic relay_one,
  output logic relay_two,
  output logic digital_output_one,
  output logic [2:0] ext_relay,
  // main motor ramp control
  output logic pid_hold,
  output logic ramp_up,
  output logic [15:0] ramp_target,
  output logic [15:0] ramp_time
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0] app_mode_q;
  amsc_rot_t rotation_mode_select;
  logic [2:0] aux_motor_total, first_cfg_q, cur_first_q, cnt_q;
  logic [15:0] on_delay_time, off_delay_time, acc_q, dec_q;
  logic [15:0] rotation_runtime_limit, runtime_min_q, min_tick_q;
  logic [6:0] pressure_error_threshold;
  logic [23:0] outfn_q;
  logic [31:0] tick_cnt_q;
  logic tick_q, main_run_q, aux_wr_q;
  logic [15:0] on_tmr_q, off_tmr_q, ramp_tmr_q;
  logic [3:0] motor_q;
  amsc_state_t state_q;
  logic relay_one_q, relay_two_q, dout_one_q;
  logic [2:0] ext_relay_q;
  logic pid_hold_q, ramp_up_q;
  logic [15:0] ramp_target_q, ramp_time_q;
  logic [15:0] mem_a, start_thr, stop_thr;
  logic acc, done, wr, tbl_hit, staging, start_cond, stop_cond;
  logic fire_on, fire_off, main_fall, rot_due;
  logic [2:0] eff_total;
  logic [1:0] next_slot, last_slot;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // byte offset maps to a register or a table word
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'b00) &&
              ((a <= OFS_RUNTIME) || (a[7:5] == TBL_PAGE));
  endfunction

  // motor slot (0..3) of the k-th start, cycling from the first index
  function automatic logic [1:0] slot(input logic [2:0] first,
                                      input logic [2:0] k,
                                      input logic [2:0] total);
    logic [3:0] f;
    logic [3:0] s;
    f = ((first == 3'h0) || (first > total)) ? 4'h0 : {1'b0, first} - 4'h1;
    s = f + {1'b0, k};
    if (s >= {1'b0, total})
      s = s - {1'b0, total};
    slot = s[1:0];
  endfunction

  // ****************************************************************
  // apb slave: one wait state on every access
  // ****************************************************************
  assign acc = psel & penable;
  assign done = acc & pready_q;
  assign wr = done & pwrite & reg_hit(paddr);
  assign tbl_hit = (paddr[7:5] == TBL_PAGE);

  // ready rises in the second access cycle, read data follows the table
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~reg_hit(paddr);
      if (acc && !pready_q)
      begin
        if (pwrite || !reg_hit(paddr))
          prdata_q <= 32'h0000_0000;
        else if (tbl_hit)
          prdata_q <= {16'h0000, mem_a};
        else
          case (paddr)
            OFS_CTRL: prdata_q <= {26'h000_0000,
                                   rotation_mode_select, app_mode_q};
            OFS_AUX: prdata_q <= {21'h00_0000, first_cfg_q,
                                  5'h00, aux_motor_total};
            OFS_ON_DLY: prdata_q <= {16'h0000, on_delay_time};
            OFS_OFF_DLY: prdata_q <= {16'h0000, off_delay_time};
            OFS_PERR: prdata_q <= {25'h000_0000, pressure_error_threshold};
            OFS_ACC: prdata_q <= {16'h0000, acc_q};
            OFS_DEC: prdata_q <= {16'h0000, dec_q};
            OFS_ROT_LIM: prdata_q <= {16'h0000, rotation_runtime_limit};
            // status: count, first index, motors, switching
            OFS_STATUS: prdata_q <= {15'h0000, pid_hold_q, 4'h0, motor_q,
                                     1'b0, cur_first_q, 1'b0, cnt_q};
            OFS_OUTFN: prdata_q <= {8'h00, outfn_q};
            OFS_RUNTIME: prdata_q <= {16'h0000, runtime_min_q};
            default: prdata_q <= 32'h0000_0000;
          endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      app_mode_q <= RST_APP;
      rotation_mode_select <= ROT_AUX;
      aux_motor_total <= RST_TOTAL;
      first_cfg_q <= RST_FIRST;
      on_delay_time <= RST_ON_DLY;
      off_delay_time <= RST_OFF_DLY;
      pressure_error_threshold <= RST_PERR;
      acc_q <= RST_ACC;
      dec_q <= RST_DEC;
      rotation_runtime_limit <= RST_ROT_LIM;
      outfn_q <= {3{OUT_FUNC_STAGING}};
    end
    else if (wr && !tbl_hit)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          app_mode_q <= pwdata[CTRL_APP_LSB +: 4];
          // the unused code reads back as none
          case (pwdata[CTRL_ROT_LSB +: 2])
            2'h1: rotation_mode_select <= ROT_AUX;
            2'h2: rotation_mode_select <= ROT_MAIN;
            default: rotation_mode_select <= ROT_NONE;
          endcase
        end
        OFS_AUX:
        begin
          // out of range totals and indices are clamped
          aux_motor_total <= (pwdata[AUX_TOTAL_LSB +: 3] > AUX_MAX) ?
                             AUX_MAX : pwdata[AUX_TOTAL_LSB +: 3];
          first_cfg_q <= (pwdata[AUX_FIRST_LSB +: 3] > AUX_MAX) ? AUX_MAX :
                         (pwdata[AUX_FIRST_LSB +: 3] == 3'h0) ? RST_FIRST :
                         pwdata[AUX_FIRST_LSB +: 3];
        end
        OFS_ON_DLY: on_delay_time <= pwdata[15:0];
        OFS_OFF_DLY: off_delay_time <= pwdata[15:0];
        OFS_PERR: pressure_error_threshold <= (pwdata[6:0] > 7'h64) ?
                                              7'h64 : pwdata[6:0];
        OFS_ACC: acc_q <= pwdata[15:0];
        OFS_DEC: dec_q <= pwdata[15:0];
        OFS_ROT_LIM: rotation_runtime_limit <= pwdata[15:0];
        OFS_OUTFN: outfn_q <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // threshold table: slot b gives next start, slot c last stop
  // ****************************************************************
  amsc_thr_mem #(
    .W(16),
    .RST_LO(RST_START_FREQ),
    .RST_HI(RST_STOP_FREQ)
  ) u_thr (
    .clk(pclk),
    .rst_n(presetn),
    .we(wr & tbl_hit),
    .waddr(paddr[4:2]),
    .wdata(pwdata[15:0]),
    .raddr_a(paddr[4:2]),
    .rdata_a(mem_a),
    .raddr_b({1'b0, next_slot}),
    .rdata_b(start_thr),
    .raddr_c({1'b1, last_slot}),
    .rdata_c(stop_thr)
  );

  // ****************************************************************
  // tenth-second tick and runtime in minutes
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ?
                    32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end
  end

  // cumulative main runtime, cleared when the rotation is taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      min_tick_q <= 16'h0000;
      runtime_min_q <= 16'h0000;
    end
    else if (main_fall && rot_due &&
             rotation_mode_select != ROT_NONE)
    begin
      min_tick_q <= 16'h0000;
      runtime_min_q <= 16'h0000;
    end
    else if (main_running && tick_q)
    begin
      if (min_tick_q == TICKS_PER_MIN - 16'h0001)
      begin
        min_tick_q <= 16'h0000;
        if (runtime_min_q != 16'hFFFF)
          runtime_min_q <= runtime_min_q + 16'h0001;
      end
      else
        min_tick_q <= min_tick_q + 16'h0001;
    end
  end

  // ****************************************************************
  // staging decisions
  // ****************************************************************
  assign staging = (app_mode_q == APP_MODE_STAGING);
  // without the card only three contactor outputs exist
  assign eff_total = (!ext_card_present && aux_motor_total > AUX_BASE_CARD)
                     ? AUX_BASE_CARD : aux_motor_total;
  assign next_slot = slot(cur_first_q, cnt_q, eff_total);
  assign last_slot = slot(cur_first_q, cnt_q - 3'h1, eff_total);
  assign start_cond = staging && main_running && state_q == ST_IDLE &&
                      cnt_q < eff_total && main_freq > start_thr &&
                      pid_error > $signed({1'b0,
                                           pressure_error_threshold});
  assign stop_cond = staging && main_running && state_q == ST_IDLE &&
                     cnt_q != 3'h0 && main_freq < stop_thr &&
                     pid_error < $signed({1'b0,
                                          pressure_error_threshold});
  assign fire_on = start_cond && on_tmr_q >= on_delay_time;
  assign fire_off = stop_cond && off_tmr_q >= off_delay_time;
  assign main_fall = main_run_q && !main_running;
  assign rot_due = runtime_min_q > rotation_runtime_limit;

  // delay timers count ticks only while every condition holds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_tmr_q <= 16'h0000;
      off_tmr_q <= 16'h0000;
    end
    else
    begin
      if (!start_cond || fire_on)
        on_tmr_q <= 16'h0000;
      else if (tick_q && on_tmr_q != 16'hFFFF)
        on_tmr_q <= on_tmr_q + 16'h0001;
      if (!stop_cond || fire_off)
        off_tmr_q <= 16'h0000;
      else if (tick_q && off_tmr_q != 16'hFFFF)
        off_tmr_q <= off_tmr_q + 16'h0001;
    end
  end

  // first-started index and its rotation on a main motor stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_first_q <= RST_FIRST;
      main_run_q <= 1'b0;
      aux_wr_q <= 1'b0;
    end
    else
    begin
      main_run_q <= main_running;
      aux_wr_q <= wr && paddr == OFS_AUX;
      if (rotation_mode_select == ROT_NONE || aux_wr_q)
        cur_first_q <= first_cfg_q;
      else if (main_fall && rot_due)
        cur_first_q <= (cur_first_q >= eff_total) ?
                       RST_FIRST : cur_first_q + 3'h1;
    end
  end

  // ****************************************************************
  // switch-over sequencer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      motor_q <= 4'h0;
      cnt_q <= 3'h0;
      ramp_tmr_q <= 16'h0000;
      pid_hold_q <= 1'b0;
      ramp_up_q <= 1'b0;
      ramp_target_q <= 16'h0000;
      ramp_time_q <= 16'h0000;
    end
    else if (!main_running || !staging)
    begin
      // aux motors never run without the main motor
      state_q <= ST_IDLE;
      motor_q <= 4'h0;
      cnt_q <= 3'h0;
      pid_hold_q <= 1'b0;
      ramp_up_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          ramp_tmr_q <= 16'h0000;
          if (fire_on)
          begin
            motor_q[next_slot] <= 1'b1;
            cnt_q <= cnt_q + 3'h1;
            state_q <= ST_RAMP_DN;
            pid_hold_q <= 1'b1;
            ramp_up_q <= 1'b0;
            ramp_time_q <= dec_q;
          end
          else if (fire_off)
          begin
            motor_q[last_slot] <= 1'b0;
            cnt_q <= cnt_q - 3'h1;
            state_q <= ST_RAMP_UP;
            pid_hold_q <= 1'b1;
            ramp_up_q <= 1'b1;
            ramp_time_q <= acc_q;
          end
        end
        ST_RAMP_DN, ST_RAMP_UP:
        begin
          // table reads settle one cycle after the count moves, the target a cycle later
          ramp_target_q <= (state_q == ST_RAMP_DN) ?
                           stop_thr : start_thr;
          if (tick_q)
            ramp_tmr_q <= ramp_tmr_q + 16'h0001;
          if (ramp_tmr_q >= ramp_time_q)
          begin
            state_q <= ST_IDLE;
            pid_hold_q <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // relay and digital outputs gated by their output function code, card relay by card presence
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay_one_q <= 1'b0;
      relay_two_q <= 1'b0;
      dout_one_q <= 1'b0;
      ext_relay_q <= 3'h0;
    end
    else
    begin
      relay_one_q <= motor_q[0] && outfn_q[7:0] == OUT_FUNC_STAGING;
      relay_two_q <= motor_q[1] &&
                     outfn_q[OUTFN_R2_LSB +: 8] == OUT_FUNC_STAGING;
      dout_one_q <= motor_q[2] &&
                    outfn_q[OUTFN_Q1_LSB +: 8] == OUT_FUNC_STAGING;
      // only the first card relay has a motor behind it
      ext_relay_q <= {2'b00, motor_q[3] & ext_card_present};
    end
  end

  assign relay_one = relay_one_q;
  assign relay_two = relay_two_q;
  assign digital_output_one = dout_one_q;
  assign ext_relay = ext_relay_q;
  assign pid_hold = pid_hold_q;
  assign ramp_up = ramp_up_q;
  assign ramp_target = ramp_target_q;
  assign ramp_time = ramp_time_q;

endmodule // amsc_top

//--- design/amsc_pkg.sv
// package: register map, field layout, reset values and timing counts
package amsc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 100;
  // one timer tick is a tenth of a second
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] TICKS_PER_MIN = 16'h0258;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AUX = 8'h04;
  localparam logic [7:0] OFS_ON_DLY = 8'h08;
  localparam logic [7:0] OFS_OFF_DLY = 8'h0C;
  localparam logic [7:0] OFS_PERR = 8'h10;
  localparam logic [7:0] OFS_ACC = 8'h14;
  localparam logic [7:0] OFS_DEC = 8'h18;
  localparam logic [7:0] OFS_ROT_LIM = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_OUTFN = 8'h24;
  localparam logic [7:0] OFS_RUNTIME = 8'h28;
  // threshold table: start 1..4 at 0x40.., stop 1..4 at 0x50..
  localparam logic [2:0] TBL_PAGE = 3'h2;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int unsigned CTRL_APP_LSB = 0;
  localparam int unsigned CTRL_ROT_LSB = 4;
  localparam int unsigned AUX_TOTAL_LSB = 0;
  localparam int unsigned AUX_FIRST_LSB = 8;
  localparam int unsigned OUTFN_R2_LSB = 8;
  localparam int unsigned OUTFN_Q1_LSB = 16;
  localparam logic [3:0] APP_MODE_STAGING = 4'h3;
  localparam logic [7:0] OUT_FUNC_STAGING = 8'h18;
  localparam logic [2:0] AUX_MAX = 3'h4;
  localparam logic [2:0] AUX_BASE_CARD = 3'h3;

  typedef enum logic [1:0] {ROT_NONE, ROT_AUX, ROT_MAIN} amsc_rot_t;
  typedef enum {ST_IDLE, ST_RAMP_DN, ST_RAMP_UP} amsc_state_t;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [3:0] RST_APP = 4'h0;
  localparam logic [2:0] RST_TOTAL = 3'h4;
  localparam logic [2:0] RST_FIRST = 3'h1;
  localparam logic [15:0] RST_ON_DLY = 16'h0258;
  localparam logic [15:0] RST_OFF_DLY = 16'h0258;
  localparam logic [6:0] RST_PERR = 7'h02;
  localparam logic [15:0] RST_ACC = 16'h0014;
  localparam logic [15:0] RST_DEC = 16'h0014;
  localparam logic [15:0] RST_ROT_LIM = 16'h10E0;
  localparam logic [15:0] RST_START_FREQ = 16'h1387;
  localparam logic [15:0] RST_STOP_FREQ = 16'h05DC;

endpackage

//--- design/amsc_thr_mem.sv
// threshold table: eight words, one write port, three registered reads
`timescale 1ns/10ps
module amsc_thr_mem #(
  parameter int unsigned W = 16,
  parameter logic [15:0] RST_LO = 16'h0000,
  parameter logic [15:0] RST_HI = 16'h0000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [W-1:0] wdata,
  // read ports
  input wire logic [2:0] raddr_a,
  output logic [W-1:0] rdata_a,
  input wire logic [2:0] raddr_b,
  output logic [W-1:0] rdata_b,
  input wire logic [2:0] raddr_c,
  output logic [W-1:0] rdata_c
);

  logic [W-1:0] mem_q [8];

  // ****************************************************************
  // storage: low half and high half reset to their own defaults
  // ****************************************************************
  for (genvar i = 0; i < 8; i++)
  begin : g_word
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        mem_q[i] <= (i < 4) ? RST_LO[W-1:0] : RST_HI[W-1:0];
      else if (we && (waddr == 3'(i)))
        mem_q[i] <= wdata;
    end
  end

  // read data registered, one cycle behind the address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_a <= '0;
      rdata_b <= '0;
      rdata_c <= '0;
    end
    else
    begin
      rdata_a <= mem_q[raddr_a];
      rdata_b <= mem_q[raddr_b];
      rdata_c <= mem_q[raddr_c];
    end
  end

endmodule // amsc_thr_mem

//--- verification/amsc_chk.sv
// checker: apb timing and staging properties at the controller ports
`timescale 1ns/10ps
module amsc_chk (
  // apb handshake
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // motor side
  input wire logic main_running,
  input wire logic signed [7:0] pid_error,
  input wire logic ext_card_present,
  input wire logic relay_one,
  input wire logic relay_two,
  input wire logic digital_output_one,
  input wire logic [2:0] ext_relay,
  input wire logic pid_hold,
  input wire logic ramp_up
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // contactors in slot order, slot one at bit zero
  wire logic [3:0] rel;
  assign rel = {ext_relay[0], digital_output_one, relay_two, relay_one};
  // a switch-over begins by adding or by removing one motor
  sequence s_start;
    $rose(pid_hold) && !ramp_up;
  endsequence
  sequence s_stop;
    $rose(pid_hold) && ramp_up;
  endsequence
  property p_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("apb wait state wrong");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_spare;
    ext_relay[2:1] == 2'b00;
  endproperty
  a_spare: assert property (p_spare) else $error("spare relay on");
  property p_card;
    $rose(ext_relay[0]) |-> $past(ext_card_present);
  endproperty
  a_card: assert property (p_card) else $error("slot 4 without card");
  property p_switch;
    $rose(pid_hold) |=> rel != $past(rel);
  endproperty
  a_switch: assert property (p_switch) else $error("hold, no switch");
  // start needs a running main motor and a positive error
  property p_start;
    s_start |=> $countones(rel) == $countones($past(rel)) + 1
      && $past(pid_error, 2) > 8'sd0 && $past(main_running, 2);
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_stop;
    s_stop |=> $countones(rel) + 1 == $countones($past(rel))
      && $past(pid_error, 2) < 8'sd100;
  endproperty
  a_stop: assert property (p_stop) else $error("bad stop");
  property p_off;
    !main_running [*2] |=> rel == 4'h0 && !pid_hold;
  endproperty
  a_off: assert property (p_off) else $error("motor on, main off");
endmodule // amsc_chk

bind amsc_top amsc_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .main_running(main_running), .pid_error(pid_error),
  .ext_card_present(ext_card_present), .relay_one(relay_one),
  .relay_two(relay_two), .digital_output_one(digital_output_one),
  .ext_relay(ext_relay), .pid_hold(pid_hold), .ramp_up(ramp_up));

//--- verification/amsc_load_model.sv
// main motor speed loop model: load demand and switch-over ramps
`timescale 1ns/10ps
module amsc_load_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // ramp request and demand
  input wire logic pid_hold,
  input wire logic [15:0] ramp_target,
  input wire logic [15:0] load_freq,
  // frequency back to the controller
  output logic [15:0] main_freq
);
  // held: go to the ramp target; free: pid settles on the load demand
  // the ramp is not slewed, so the controller sees its target one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      main_freq <= 16'h0000;
    else
      main_freq <= pid_hold ? ramp_target : load_freq;
  end
endmodule // amsc_load_model

//--- verification/amsc_top_tb_top.sv
// testbench: register defaults, staging order, first motor rotation
`timescale 1ns/10ps
module amsc_top_tb_top;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} amsc_row_t;
  logic pclk = 1'b0, presetn = 1'b0, run = 1'b0, card = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, relay_one, relay_two, digital_output_one;
  logic pid_hold, ramp_up;
  logic [2:0] ext_relay;
  logic [15:0] ramp_target, ramp_time, main_freq, load = 16'h0000;
  logic signed [7:0] err = 8'sh00;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  wire logic [3:0] rel;
  assign rel = {ext_relay[0], digital_output_one, relay_two, relay_one};
  // read rows: address, expected data, expected error
  amsc_row_t rows [13] = '{
    '{8'h00, 32'h0000_0010, 1'b0},
    '{8'h04, 32'h0000_0104, 1'b0},
    '{8'h08, 32'h0000_0258, 1'b0},
    '{8'h0C, 32'h0000_0258, 1'b0},
    '{8'h10, 32'h0000_0002, 1'b0},
    '{8'h14, 32'h0000_0014, 1'b0},
    '{8'h18, 32'h0000_0014, 1'b0},
    '{8'h1C, 32'h0000_10E0, 1'b0},
    '{8'h20, 32'h0000_0010, 1'b0},
    '{8'h24, 32'h0018_1818, 1'b0},
    '{8'h40, 32'h0000_1387, 1'b0},
    '{8'h50, 32'h0000_05DC, 1'b0},
    '{8'h30, 32'h0000_0000, 1'b1}};
  amsc_top #(.TICK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_running(run), .main_freq(main_freq),
    .pid_error(err), .ext_card_present(card), .relay_one(relay_one),
    .relay_two(relay_two), .digital_output_one(digital_output_one),
    .ext_relay(ext_relay), .pid_hold(pid_hold), .ramp_up(ramp_up),
    .ramp_target(ramp_target), .ramp_time(ramp_time));
  amsc_load_model u_load (.pclk(pclk), .presetn(presetn),
    .pid_hold(pid_hold), .ramp_target(ramp_target), .load_freq(load),
    .main_freq(main_freq));
  // 40 mhz clock
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  // hang guard, with margin
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer; an idle cycle first keeps drives single per step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait, bounded, for a contactor pattern
  task automatic wait_rel(input logic [3:0] e);
    int n;
    n = 0;
    while (rel !== e && n < 400)
    begin
      n++;
      @(posedge pclk);
    end
    chk("relays", {28'h0, e}, {28'h0, rel});
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    chk("reset relays", 32'h0, {28'h0, rel});
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk("rdata", rows[i].d, rd);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, serr});
    end
    // short delays and ramps, four motors from slot two, no rotation
    apb(1'b1, 8'h08, 32'h0000_0002);
    apb(1'b1, 8'h0C, 32'h0000_0002);
    apb(1'b1, 8'h14, 32'h0000_0001);
    apb(1'b1, 8'h18, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0204);
    apb(1'b1, 8'h00, 32'h0000_0003);
    err <= 8'sd2;
    load <= 16'h157C;
    run <= 1'b1;
    repeat (60) @(posedge pclk);
    chk("equal error", 32'h0, {28'h0, rel});
    err <= 8'sd10;
    wait_rel(4'b0010);
    chk("ramp", 32'h05DC_0001, {ramp_target, ramp_time});
    wait_rel(4'b0110);
    wait_rel(4'b1110);
    wait_rel(4'b1111);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("run count", 32'h4, {29'h0, rd[2:0]});
    err <= -8'sd5;
    load <= 16'h03E8;
    wait_rel(4'b1110);
    wait_rel(4'b0110);
    wait_rel(4'b0010);
    wait_rel(4'b0000);
    // leaving the staging mode drops every motor
    err <= 8'sd10;
    load <= 16'h157C;
    wait_rel(4'b0010);
    apb(1'b1, 8'h00, 32'h0000_0000);
    wait_rel(4'b0000);
    // a lapse of the error restarts the start timer
    apb(1'b1, 8'h08, 32'h0000_0008);
    err <= 8'sd0;
    apb(1'b1, 8'h00, 32'h0000_0003);
    err <= 8'sd10;
    repeat (24) @(posedge pclk);
    err <= 8'sd0;
    @(posedge pclk);
    err <= 8'sd10;
    repeat (24) @(posedge pclk);
    chk("timer restart", 32'h0, {28'h0, rel});
    wait_rel(4'b0010);
    // rotation: none keeps slot two, then aux, main, aux with wrap
    err <= 8'sd0;
    apb(1'b1, 8'h1C, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 8'h00, {26'h0, 2'(k == 0 ? 0 : (k == 2 ? 2 : 1)), 4'h3});
      run <= 1'b0;
      repeat (4) @(posedge pclk);
      run <= 1'b1;
      repeat (2800) @(posedge pclk);
      run <= 1'b0;
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("first slot", k == 3 ? 1 : k + 2, {29'h0, rd[6:4]});
    end
    complete_run();
  end
endmodule // amsc_top_tb_top
